// *** verilog/facd_decoder.sv ***
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "facd_map.svh"
// What this block does
// RL1 - dump slot: sectors after format, else end-of-track
// RL2 - dumped drive bits stay internal only
// RL3 - host keeps drive bits matching output register
// RL4 - data transfers share parameters and results
// RL5 - implied seek runs first when enabled
// RL6 - drive busy bit set during implied seek
// RL7 - seek failure reported in transfer results
// RL8 - failure: error in status zero, failing cylinder
// RL9 - invalid opcode: standby, single 80h result
// RL10 - perpendicular setup decoded, second byte stored
// RL11 - capture first error-free ID on cylinder
// RL12 - read-ID returns three status, C H R N
// RL13 - after invalid result, await new command
module facd_decoder #(
	parameter int RES_DEPTH = 10
)(
	input wire logic clk_sys_i, // system clock
	input wire logic resetn_i, // synchronous reset, active low
	input wire logic [1:0] reg_addr_i, // register word index
	input wire logic [7:0] reg_wdata_i, // register write data
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	output logic [7:0] reg_rdata_o, // register read data, one cycle later
	output logic irq_o, // level interrupt
	input wire logic cmd_wr_i, // host writes a command byte
	input wire logic [7:0] cmd_data_i, // command byte
	output logic cmd_ready_o, // command bytes accepted
	output logic res_valid_o, // result byte available
	output logic [7:0] res_data_o, // current result byte
	input wire logic res_rd_i, // host pops a result byte
	output logic standby_o, // standby after invalid opcode
	output logic [3:0] drive_busy_o, // main status drive busy bits
	output logic seek_req_o, // implied seek request, level
	output logic [1:0] seek_drive_o, // drive for seek
	output logic [7:0] seek_cyl_o, // target cylinder
	input wire logic seek_done_i, // seek ended, one-cycle pulse
	input wire logic seek_fail_i, // seek failed, beside done
	input wire logic [7:0] seek_fail_cyl_i, // cylinder where it failed
	output logic xfer_start_o, // start data phase, pulse
	input wire logic xfer_done_i, // data phase ended, pulse
	input wire logic [7:0] xfer_st0_i, // transfer status zero
	input wire logic [7:0] xfer_st1_i, // transfer status one
	input wire logic [7:0] xfer_st2_i, // transfer status two
	input wire logic [31:0] xfer_chrn_i, // transfer C,H,R,N high to low
	output logic id_search_o, // read-ID search active
	input wire logic id_valid_i, // an ID field was read, pulse
	input wire logic id_crc_ok_i, // that ID field was error free
	input wire logic [31:0] id_chrn_i, // ID C,H,R,N high to low
	input wire logic id_not_found_i // search gave up, pulse
);

	// refused at elaboration: the dump needs ten result slots
	if (RES_DEPTH < 10)
	begin : g_depth_check
		$error("RES_DEPTH must hold the ten dump bytes");
	end

	function automatic logic is_xfer(input logic [4:0] op);
		begin
			is_xfer = (op == `FACD_OP_RD_DATA) || (op == `FACD_OP_WR_DATA) ||
				(op == `FACD_OP_RD_DEL) || (op == `FACD_OP_WR_DEL) ||
				(op == `FACD_OP_VERIFY) || (op == `FACD_OP_RD_TRACK);
		end
	endfunction : is_xfer

	function automatic facd_pkg::facd_cmd_t decode(input logic [7:0] op);
		begin
			if (op == `FACD_OP_SPECIFY)
				decode = facd_pkg::CMD_SPECIFY;
			else if (op == `FACD_OP_CONFIGURE)
				decode = facd_pkg::CMD_CONFIGURE;
			else if (op == `FACD_OP_PERP)
				decode = facd_pkg::CMD_PERP; // [RL10]
			else if (op == `FACD_OP_DUMP)
				decode = facd_pkg::CMD_DUMP;
			else if ({op[7], op[5:0]} == {1'b0, 1'b0, `FACD_OP_READ_ID})
				decode = facd_pkg::CMD_READ_ID;
			else if ({op[7], op[5:0]} == {1'b0, 1'b0, `FACD_OP_FORMAT})
				decode = facd_pkg::CMD_FORMAT;
			else if (is_xfer(op[4:0]))
				decode = facd_pkg::CMD_XFER; // [RL4]
			else
				decode = facd_pkg::CMD_NONE;
		end
	endfunction : decode

	function automatic logic [3:0] npar(input facd_pkg::facd_cmd_t c);
		begin
			unique case (c)
				facd_pkg::CMD_SPECIFY: npar = `FACD_NPAR_SPECIFY;
				facd_pkg::CMD_CONFIGURE: npar = `FACD_NPAR_CONFIGURE;
				facd_pkg::CMD_PERP: npar = `FACD_NPAR_PERP;
				facd_pkg::CMD_READ_ID: npar = `FACD_NPAR_READ_ID;
				facd_pkg::CMD_FORMAT: npar = `FACD_NPAR_FORMAT;
				facd_pkg::CMD_XFER: npar = `FACD_NPAR_XFER;
				facd_pkg::CMD_DUMP, facd_pkg::CMD_NONE: npar = 4'h0;
			endcase
		end
	endfunction : npar

	////////////////////////////////////////////////////////////////////////////

	facd_pkg::facd_state_t state_ff;
	facd_pkg::facd_cmd_t cmd_ff;
	logic [3:0] par_cnt_ff;
	logic [7:0] par_ff [0:7];
	logic [7:0] pcn_ff [0:3];
	logic [7:0] spec_ff [0:1];
	logic [7:0] config_ff;
	logic [7:0] precomp_start_track_ff;
	logic [7:0] perp_ff;
	logic [7:0] sc_ff;
	logic [7:0] eot_ff;
	logic last_fmt_ff;
	logic [7:0] res_mem_ff [0:RES_DEPTH-1];
	logic [3:0] res_cnt_ff;
	logic [3:0] res_idx_ff;
	logic [7:0] res_data_ff;
	logic standby_ff;
	logic xfer_start_ff;
	logic [`FACD_IRQ_WIDTH-1:0] irq_stat_ff;
	logic [`FACD_IRQ_WIDTH-1:0] irq_mask_ff;
	logic [7:0] reg_rdata_ff;
	logic [`FACD_IRQ_WIDTH-1:0] nxt_events;
	facd_pkg::facd_cmd_t first_cmd;
	logic first_byte;
	logic last_par;
	logic [7:0] sel_byte;
	logic [7:0] cur_st0;

	assign first_cmd = decode(cmd_data_i);
	assign first_byte = cmd_wr_i && (state_ff == facd_pkg::ST_IDLE);
	assign last_par = cmd_wr_i && (state_ff == facd_pkg::ST_PARAM) &&
		(par_cnt_ff == npar(cmd_ff) - 4'h1);
	// status zero echoes head and drive of the selected unit
	assign sel_byte = par_ff[0];
	assign cur_st0 = {5'h00, sel_byte[2:0]};

	assign cmd_ready_o = (state_ff == facd_pkg::ST_IDLE) || (state_ff == facd_pkg::ST_PARAM);
	assign res_valid_o = (state_ff == facd_pkg::ST_RESULT);
	assign res_data_o = res_data_ff;
	assign standby_o = standby_ff;
	assign seek_req_o = (state_ff == facd_pkg::ST_SEEK); // [RL5]
	assign seek_drive_o = sel_byte[1:0];
	assign seek_cyl_o = par_ff[1];
	assign xfer_start_o = xfer_start_ff;
	assign id_search_o = (state_ff == facd_pkg::ST_READ_ID);
	assign reg_rdata_o = reg_rdata_ff;
	assign irq_o = |(irq_stat_ff & irq_mask_ff);

	genvar gd;
	generate
		for (gd = 0; gd < 4; gd++)
		begin : g_busy
			assign drive_busy_o[gd] = seek_req_o && (sel_byte[1:0] == 2'(gd)); // [RL6]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// command sequencing

	always_ff @(posedge clk_sys_i)
	begin
		xfer_start_ff <= 1'b0;
		if (!resetn_i)
		begin
			state_ff <= facd_pkg::ST_IDLE;
			cmd_ff <= facd_pkg::CMD_NONE;
			par_cnt_ff <= 4'h0;
		end
		else
		begin
			unique case (state_ff)
				facd_pkg::ST_IDLE:
					if (cmd_wr_i)
					begin
						cmd_ff <= first_cmd;
						par_cnt_ff <= 4'h0;
						if (first_cmd == facd_pkg::CMD_NONE || first_cmd == facd_pkg::CMD_DUMP)
							state_ff <= facd_pkg::ST_RESULT; // [RL9]
						else
							state_ff <= facd_pkg::ST_PARAM;
					end
				facd_pkg::ST_PARAM:
					if (cmd_wr_i)
					begin
						par_cnt_ff <= par_cnt_ff + 4'h1;
						if (last_par)
						begin
							unique case (cmd_ff)
								facd_pkg::CMD_READ_ID: state_ff <= facd_pkg::ST_READ_ID;
								facd_pkg::CMD_FORMAT:
								begin
									state_ff <= facd_pkg::ST_XFER;
									xfer_start_ff <= 1'b1;
								end
								facd_pkg::CMD_XFER:
									if (config_ff[6])
										state_ff <= facd_pkg::ST_SEEK; // [RL5]
									else
									begin
										state_ff <= facd_pkg::ST_XFER;
										xfer_start_ff <= 1'b1;
									end
								default: state_ff <= facd_pkg::ST_IDLE;
							endcase
						end
					end
				facd_pkg::ST_SEEK:
					if (seek_done_i)
					begin
						if (seek_fail_i)
							state_ff <= facd_pkg::ST_RESULT; // [RL7]
						else
						begin
							state_ff <= facd_pkg::ST_XFER;
							xfer_start_ff <= 1'b1;
						end
					end
				facd_pkg::ST_XFER:
					if (xfer_done_i)
						state_ff <= facd_pkg::ST_RESULT;
				facd_pkg::ST_READ_ID:
					if ((id_valid_i && id_crc_ok_i) || id_not_found_i)
						state_ff <= facd_pkg::ST_RESULT; // [RL11]
				facd_pkg::ST_RESULT:
					if (res_rd_i && res_idx_ff == res_cnt_ff - 4'h1)
						state_ff <= facd_pkg::ST_IDLE; // [RL13]
			endcase
		end
	end

	// parameter capture; first slot cleared for commands without one
	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < 8; i++)
				par_ff[i] <= `FACD_RST_BYTE;
		end
		else if (first_byte)
			par_ff[0] <= `FACD_RST_BYTE;
		else if (cmd_wr_i && state_ff == facd_pkg::ST_PARAM)
			par_ff[par_cnt_ff[2:0]] <= cmd_data_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// internal parameters kept for the dump

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			spec_ff[0] <= `FACD_RST_BYTE;
			spec_ff[1] <= `FACD_RST_BYTE;
			config_ff <= `FACD_RST_CONFIG;
			precomp_start_track_ff <= `FACD_RST_PRECOMP_START_TRACK;
			perp_ff <= `FACD_RST_BYTE;
			sc_ff <= `FACD_RST_BYTE;
			eot_ff <= `FACD_RST_BYTE;
			last_fmt_ff <= 1'b0;
		end
		else if (cmd_wr_i && state_ff == facd_pkg::ST_PARAM)
		begin
			unique case (cmd_ff)
				facd_pkg::CMD_SPECIFY: spec_ff[par_cnt_ff[0]] <= cmd_data_i;
				facd_pkg::CMD_CONFIGURE:
					if (par_cnt_ff == 4'h1)
						config_ff <= cmd_data_i;
					else if (par_cnt_ff == 4'h2)
						precomp_start_track_ff <= cmd_data_i;
				facd_pkg::CMD_PERP:
					// drive bits follow only when the overwrite bit is set
					if (cmd_data_i[7])
						perp_ff <= {1'b0, 1'b0, cmd_data_i[5:0]}; // [RL10]
					else
						perp_ff <= {2'b00, perp_ff[5:2], cmd_data_i[1:0]}; // [RL10]
				facd_pkg::CMD_FORMAT:
					if (par_cnt_ff == 4'h2)
					begin
						sc_ff <= cmd_data_i; // [RL1]
						last_fmt_ff <= 1'b1;
					end
				facd_pkg::CMD_XFER:
					if (par_cnt_ff == 4'h5)
					begin
						eot_ff <= cmd_data_i; // [RL1]
						last_fmt_ff <= 1'b0;
					end
				default: ;
			endcase
		end
	end

	// present cylinder per drive, tracked from finished seeks
	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < 4; i++)
				pcn_ff[i] <= `FACD_RST_BYTE;
		end
		else if (state_ff == facd_pkg::ST_SEEK && seek_done_i)
			pcn_ff[sel_byte[1:0]] <= seek_fail_i ? seek_fail_cyl_i : seek_cyl_o;
	end

	////////////////////////////////////////////////////////////////////////////
	// result bytes

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < RES_DEPTH; i++)
				res_mem_ff[i] <= `FACD_RST_BYTE;
			res_cnt_ff <= 4'h0;
			res_idx_ff <= 4'h0;
			res_data_ff <= `FACD_RST_BYTE;
		end
		else if (first_byte && first_cmd == facd_pkg::CMD_NONE)
		begin
			res_data_ff <= `FACD_ST0_INVALID; // [RL9]
			res_cnt_ff <= `FACD_NRES_INVALID;
			res_idx_ff <= 4'h0;
		end
		else if (first_byte && first_cmd == facd_pkg::CMD_DUMP)
		begin
			res_mem_ff[0] <= pcn_ff[0];
			res_mem_ff[1] <= pcn_ff[1];
			res_mem_ff[2] <= pcn_ff[2];
			res_mem_ff[3] <= pcn_ff[3];
			res_mem_ff[4] <= spec_ff[0];
			res_mem_ff[5] <= spec_ff[1];
			res_mem_ff[6] <= last_fmt_ff ? sc_ff : eot_ff; // [RL1]
			// drive bits exist only here; nothing drives select pins [RL2]
			res_mem_ff[7] <= perp_ff;
			res_mem_ff[8] <= config_ff;
			res_mem_ff[9] <= precomp_start_track_ff;
			res_data_ff <= pcn_ff[0];
			res_cnt_ff <= `FACD_NRES_DUMP;
			res_idx_ff <= 4'h0;
		end
		else if (state_ff == facd_pkg::ST_SEEK && seek_done_i && seek_fail_i)
		begin
			res_mem_ff[0] <= cur_st0 | `FACD_ST0_ABNORMAL | `FACD_ST0_EQUIP_CHECK; // [RL8]
			res_mem_ff[1] <= `FACD_RST_BYTE;
			res_mem_ff[2] <= `FACD_RST_BYTE;
			res_mem_ff[3] <= seek_fail_cyl_i; // [RL8]
			res_mem_ff[4] <= par_ff[2];
			res_mem_ff[5] <= par_ff[3];
			res_mem_ff[6] <= par_ff[4];
			res_data_ff <= cur_st0 | `FACD_ST0_ABNORMAL | `FACD_ST0_EQUIP_CHECK;
			res_cnt_ff <= `FACD_NRES_XFER; // [RL7]
			res_idx_ff <= 4'h0;
		end
		else if (state_ff == facd_pkg::ST_XFER && xfer_done_i)
		begin
			res_mem_ff[0] <= xfer_st0_i; // [RL4]
			res_mem_ff[1] <= xfer_st1_i;
			res_mem_ff[2] <= xfer_st2_i;
			for (int i = 0; i < 4; i++)
				res_mem_ff[3+i] <= xfer_chrn_i[31-8*i -: 8];
			res_data_ff <= xfer_st0_i;
			res_cnt_ff <= `FACD_NRES_XFER;
			res_idx_ff <= 4'h0;
		end
		else if (state_ff == facd_pkg::ST_READ_ID && id_not_found_i)
		begin
			res_mem_ff[0] <= cur_st0 | `FACD_ST0_ABNORMAL;
			res_mem_ff[1] <= `FACD_ST1_NO_DATA;
			res_mem_ff[2] <= `FACD_RST_BYTE;
			for (int i = 0; i < 4; i++)
				res_mem_ff[3+i] <= `FACD_RST_BYTE;
			res_data_ff <= cur_st0 | `FACD_ST0_ABNORMAL;
			res_cnt_ff <= `FACD_NRES_XFER;
			res_idx_ff <= 4'h0;
		end
		else if (state_ff == facd_pkg::ST_READ_ID && id_valid_i && id_crc_ok_i)
		begin
			// bad-CRC fields are passed over; only the first good one lands
			res_mem_ff[0] <= cur_st0; // [RL12]
			res_mem_ff[1] <= `FACD_RST_BYTE;
			res_mem_ff[2] <= `FACD_RST_BYTE;
			for (int i = 0; i < 4; i++)
				res_mem_ff[3+i] <= id_chrn_i[31-8*i -: 8]; // [RL11]
			res_data_ff <= cur_st0;
			res_cnt_ff <= `FACD_NRES_XFER; // [RL12]
			res_idx_ff <= 4'h0;
		end
		else if (state_ff == facd_pkg::ST_RESULT && res_rd_i)
		begin
			res_idx_ff <= res_idx_ff + 4'h1;
			res_data_ff <= res_mem_ff[res_idx_ff + 4'h1];
		end
	end

	// standby holds from an invalid opcode until the next command byte
	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
			standby_ff <= 1'b0;
		else if (first_byte)
			standby_ff <= (first_cmd == facd_pkg::CMD_NONE); // [RL9]
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts and software registers

	always_comb
	begin
		nxt_events = '0;
		nxt_events[`FACD_IRQ_RESULT] = (state_ff != facd_pkg::ST_RESULT) &&
			(state_ff != facd_pkg::ST_IDLE) && (state_ff != facd_pkg::ST_PARAM) &&
			((seek_done_i && seek_fail_i && state_ff == facd_pkg::ST_SEEK) ||
			(xfer_done_i && state_ff == facd_pkg::ST_XFER) ||
			(state_ff == facd_pkg::ST_READ_ID && (id_not_found_i || (id_valid_i && id_crc_ok_i))));
		nxt_events[`FACD_IRQ_INVALID] = first_byte && (first_cmd == facd_pkg::CMD_NONE);
		nxt_events[`FACD_IRQ_SEEK_FAIL] = (state_ff == facd_pkg::ST_SEEK) && seek_done_i &&
			seek_fail_i;
		nxt_events[`FACD_IRQ_ID_FOUND] = (state_ff == facd_pkg::ST_READ_ID) && id_valid_i &&
			id_crc_ok_i;
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
			irq_stat_ff <= '0;
		else if (reg_wr_i && reg_addr_i == `FACD_OFF_IRQ_STAT)
			irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[`FACD_IRQ_WIDTH-1:0]) | nxt_events;
		else
			irq_stat_ff <= irq_stat_ff | nxt_events;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
			irq_mask_ff <= '0;
		else if (reg_wr_i && reg_addr_i == `FACD_OFF_IRQ_MASK)
			irq_mask_ff <= reg_wdata_i[`FACD_IRQ_WIDTH-1:0];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
			reg_rdata_ff <= `FACD_RST_BYTE;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`FACD_OFF_IRQ_STAT: reg_rdata_ff <= {4'h0, irq_stat_ff};
				`FACD_OFF_IRQ_MASK: reg_rdata_ff <= {4'h0, irq_mask_ff};
				`FACD_OFF_CONFIG: reg_rdata_ff <= config_ff;
				`FACD_OFF_STATE: reg_rdata_ff <= {standby_ff, last_fmt_ff, 3'h0,
					state_ff};
			endcase
		end
		else
			reg_rdata_ff <= `FACD_RST_BYTE;
	end

endmodule : facd_decoder

// *** verilog/facd_map.svh ***
`ifndef FACD_MAP_SVH
`define FACD_MAP_SVH

// software register offsets (word index on the plain port)
`define FACD_OFF_IRQ_STAT 2'h0
`define FACD_OFF_IRQ_MASK 2'h1
`define FACD_OFF_CONFIG 2'h2
`define FACD_OFF_STATE 2'h3

// interrupt status bit positions
`define FACD_IRQ_RESULT 0
`define FACD_IRQ_INVALID 1
`define FACD_IRQ_SEEK_FAIL 2
`define FACD_IRQ_ID_FOUND 3
`define FACD_IRQ_WIDTH 4

// opcode patterns
`define FACD_OP_SPECIFY 8'h03
`define FACD_OP_CONFIGURE 8'h13
`define FACD_OP_PERP 8'h12
`define FACD_OP_DUMP 8'h0E
`define FACD_OP_READ_ID 5'h0A
`define FACD_OP_FORMAT 5'h0D
`define FACD_OP_RD_DATA 5'h06
`define FACD_OP_WR_DATA 5'h05
`define FACD_OP_RD_DEL 5'h0C
`define FACD_OP_WR_DEL 5'h09
`define FACD_OP_VERIFY 5'h16
`define FACD_OP_RD_TRACK 5'h02

// parameter byte counts following the first byte
`define FACD_NPAR_SPECIFY 4'h2
`define FACD_NPAR_CONFIGURE 4'h3
`define FACD_NPAR_PERP 4'h1
`define FACD_NPAR_READ_ID 4'h1
`define FACD_NPAR_FORMAT 4'h5
`define FACD_NPAR_XFER 4'h8

// result byte counts
`define FACD_NRES_INVALID 4'h1
`define FACD_NRES_XFER 4'h7
`define FACD_NRES_DUMP 4'hA

// status byte values
`define FACD_ST0_INVALID 8'h80
`define FACD_ST0_ABNORMAL 8'h40
`define FACD_ST0_EQUIP_CHECK 8'h10
`define FACD_ST1_NO_DATA 8'h04

// reset values
`define FACD_RST_CONFIG 8'h00
`define FACD_RST_PRECOMP_START_TRACK 8'h00
`define FACD_RST_BYTE 8'h00

`endif

// *** verilog/facd_pkg.sv ***
package facd_pkg;

	typedef enum logic [2:0]
	{
		CMD_NONE,
		CMD_SPECIFY,
		CMD_CONFIGURE,
		CMD_PERP,
		CMD_DUMP,
		CMD_READ_ID,
		CMD_FORMAT,
		CMD_XFER
	} facd_cmd_t;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_PARAM,
		ST_SEEK,
		ST_XFER,
		ST_READ_ID,
		ST_RESULT
	} facd_state_t;

endpackage : facd_pkg

// *** verification/facd_monitor.sv ***
`timescale 1ns/10ps
module facd_monitor #(
	parameter int RES_DEPTH = 10
)(
	input wire logic clk_sys_i, // clock
	input wire logic resetn_i, // reset
	input wire logic standby_o, // standby
	input wire logic res_valid_o, // result ready
	input wire logic [7:0] res_data_o, // result byte
	input wire logic res_rd_i, // result pop
	input wire logic cmd_ready_o, // bytes taken
	input wire logic seek_req_o, // seek active
	input wire logic [1:0] seek_drive_o, // seek drive
	input wire logic [3:0] drive_busy_o, // busy bits
	input wire logic seek_done_i, // seek end
	input wire logic seek_fail_i, // seek failed
	input wire logic xfer_start_o, // data start
	input wire logic id_search_o, // id search
	input wire logic id_valid_i, // id read
	input wire logic id_crc_ok_i // id good
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	a_invalid_byte: assert property ($rose(standby_o) |-> res_valid_o && res_data_o == 8'h80)
		else $error("invalid opcode result wrong");
	a_invalid_single: assert property (standby_o && res_valid_o && res_rd_i |=> !res_valid_o && cmd_ready_o)
		else $error("invalid opcode result longer than one byte");
	a_ports_apart: assert property (res_valid_o |-> !cmd_ready_o)
		else $error("command bytes taken during result");
	a_busy_seek: assert property (seek_req_o |-> drive_busy_o == 4'h1 << seek_drive_o)
		else $error("busy bit wrong during seek");
	a_busy_idle: assert property (!seek_req_o |-> drive_busy_o == 4'h0)
		else $error("busy bit outside seek");
	a_seek_then_xfer: assert property (seek_req_o && seek_done_i && !seek_fail_i
		|-> !xfer_start_o ##1 xfer_start_o ##1 !xfer_start_o)
		else $error("transfer did not follow seek");
	a_seek_fail_res: assert property (seek_req_o && seek_done_i && seek_fail_i
		|=> res_valid_o && !xfer_start_o && res_data_o[7:4] == 4'h5)
		else $error("seek failure not in results");
	a_id_good: assert property (id_search_o && id_valid_i && id_crc_ok_i
		|=> res_valid_o && res_data_o[7:3] == 5'h00)
		else $error("good id not returned");
	a_id_bad: assert property (id_search_o && id_valid_i && !id_crc_ok_i
		|=> id_search_o && !res_valid_o)
		else $error("bad id field taken");
endmodule : facd_monitor

bind facd_decoder facd_monitor #(.RES_DEPTH(RES_DEPTH)) mon (.clk_sys_i, .resetn_i, .standby_o,
	.res_valid_o, .res_data_o, .res_rd_i, .cmd_ready_o, .seek_req_o, .seek_drive_o,
	.drive_busy_o, .seek_done_i, .seek_fail_i, .xfer_start_o, .id_search_o, .id_valid_i,
	.id_crc_ok_i);

// *** verification/facd_drive_model.sv ***
`timescale 1ns/10ps
module facd_drive_model #(
	parameter logic [31:0] XCHRN = 32'h0000_0000,
	parameter logic [31:0] IDCHRN = 32'h0000_0000
)(
	input wire logic clk_sys_i, // clock
	input wire logic resetn_i, // reset
	input wire logic [7:0] dly_i, // answer delay
	input wire logic fail_i, // seek fails
	input wire logic [7:0] fcyl_i, // fail cylinder
	input wire logic bad_i, // first id bad
	input wire logic miss_i, // no id found
	input wire logic seek_req_i, // seek request
	input wire logic xfer_start_i, // data start
	input wire logic id_search_i, // id search
	output logic seek_done_o, // seek end
	output logic seek_fail_o, // seek failed
	output logic [7:0] seek_fail_cyl_o, // fail cylinder
	output logic xfer_done_o, // data end
	output logic [23:0] xfer_st_o, // status bytes
	output logic [31:0] xfer_chrn_o, // data chrn
	output logic id_valid_o, // id read
	output logic id_crc_ok_o, // id good
	output logic [31:0] id_chrn_o, // id chrn
	output logic id_not_found_o // gave up
);
	logic [7:0] cnt_ff = 8'h00;
	logic busy_ff = 1'b0;
	logic first_ff = 1'b1;
	logic act;
	initial {seek_done_o, xfer_done_o, id_valid_o, id_crc_ok_o, id_not_found_o} = 5'h00;
	assign act = (seek_req_i && !seek_done_o) || busy_ff
		|| (id_search_i && !id_valid_o && !id_not_found_o);
	// unqualified data lines show junk, never the last good value
	assign seek_fail_o = seek_done_o ? fail_i : !fail_i;
	assign seek_fail_cyl_o = seek_done_o ? fcyl_i : ~fcyl_i;
	assign xfer_st_o = xfer_done_o ? 24'h01_0000 : 24'hFE_FFFF;
	assign xfer_chrn_o = xfer_done_o ? XCHRN : ~XCHRN;
	assign id_chrn_o = id_valid_o && id_crc_ok_o ? IDCHRN : ~IDCHRN;
	always @(posedge clk_sys_i)
	begin
		seek_done_o <= 1'b0;
		xfer_done_o <= 1'b0;
		id_valid_o <= 1'b0;
		id_not_found_o <= 1'b0;
		if (xfer_start_i)
			busy_ff <= 1'b1;
		if (!id_search_i)
			first_ff <= 1'b1;
		if (!resetn_i || !act)
			cnt_ff <= 8'h00;
		else if (cnt_ff < dly_i)
			cnt_ff <= cnt_ff + 8'h01;
		else
		begin
			cnt_ff <= 8'h00;
			if (busy_ff)
			begin
				xfer_done_o <= 1'b1;
				busy_ff <= 1'b0;
			end
			else if (seek_req_i)
				seek_done_o <= 1'b1;
			else if (miss_i)
				id_not_found_o <= 1'b1;
			else
			begin
				id_valid_o <= 1'b1;
				id_crc_ok_o <= !(bad_i && first_ff);
				first_ff <= 1'b0;
			end
		end
		if (!resetn_i)
			busy_ff <= 1'b0;
	end
endmodule : facd_drive_model

// *** verification/facd_decoder_tb.sv ***
`timescale 1ns/10ps
`include "facd_map.svh"
module facd_decoder_tb;
	typedef logic [7:0] facd_bq_t[$];
	localparam logic [31:0] XC = 32'h0500_0302;
	localparam logic [31:0] IC = 32'h0701_0402;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [7:0] reg_wdata_i = 8'h00, cmd_data_i = 8'h00;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, cmd_wr_i = 1'b0, res_rd_i = 1'b0;
	logic [7:0] reg_rdata_o, res_data_o, seek_cyl_o, seek_fail_cyl_i;
	logic irq_o, cmd_ready_o, res_valid_o, standby_o, seek_req_o, xfer_start_o, id_search_o;
	logic [3:0] drive_busy_o;
	logic [1:0] seek_drive_o;
	logic seek_done_i, seek_fail_i, xfer_done_i, id_valid_i, id_crc_ok_i, id_not_found_i;
	logic [7:0] xfer_st0_i, xfer_st1_i, xfer_st2_i;
	logic [31:0] xfer_chrn_i, id_chrn_i;
	logic [7:0] dly = 8'h02;
	logic fail = 1'b0, bad = 1'b0, miss = 1'b0;
	logic [4:0] ops[6] = '{`FACD_OP_RD_DATA, `FACD_OP_WR_DATA, `FACD_OP_RD_DEL,
		`FACD_OP_WR_DEL, `FACD_OP_VERIFY, `FACD_OP_RD_TRACK};
	int err_count = 0;
	int compares = 0;

	always #5 clk_sys_i = ~clk_sys_i;
	facd_decoder dut (.*);
	facd_drive_model #(.XCHRN(XC), .IDCHRN(IC)) drv (.clk_sys_i, .resetn_i, .dly_i(dly),
		.fail_i(fail), .fcyl_i(8'h03), .bad_i(bad), .miss_i(miss), .seek_req_i(seek_req_o),
		.xfer_start_i(xfer_start_o), .id_search_i(id_search_o), .seek_done_o(seek_done_i),
		.seek_fail_o(seek_fail_i), .seek_fail_cyl_o(seek_fail_cyl_i), .xfer_done_o(xfer_done_i),
		.xfer_st_o({xfer_st0_i, xfer_st1_i, xfer_st2_i}), .xfer_chrn_o(xfer_chrn_i),
		.id_valid_o(id_valid_i), .id_crc_ok_o(id_crc_ok_i), .id_chrn_o(id_chrn_i),
		.id_not_found_o(id_not_found_i));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_sys_i);
		chk(reg_rdata_o, e);
	endtask : rd

	task automatic send(input facd_bq_t q);
		foreach (q[i])
		begin
			cmd_data_i <= q[i];
			cmd_wr_i <= 1'b1;
			@(posedge clk_sys_i);
		end
		cmd_wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : send

	// waits for the result phase, pops every byte back to back
	task automatic pop(input facd_bq_t e);
		int n;
		n = 0;
		while (res_valid_o !== 1'b1 && n < 500)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		foreach (e[i])
		begin
			res_rd_i <= 1'b1;
			@(posedge clk_sys_i);
			chk({res_valid_o, res_data_o}, {1'b1, e[i]});
		end
		res_rd_i <= 1'b0;
		@(posedge clk_sys_i);
		chk({res_valid_o, cmd_ready_o}, 2'b01);
	endtask : pop

	function automatic facd_bq_t r7(input logic [23:0] s, input logic [31:0] c);
		return {s[23:16], s[15:8], s[7:0], c[31:24], c[23:16], c[15:8], c[7:0]};
	endfunction : r7

	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		err_count++;
		conclude();
	end

	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
		chk({cmd_ready_o, res_valid_o, irq_o, standby_o}, 4'b1000);
		rd(`FACD_OFF_CONFIG, `FACD_RST_CONFIG);
		send({8'hFF});
		chk(standby_o, 1'b1);
		rd(`FACD_OFF_IRQ_STAT, 8'h02);
		chk(irq_o, 1'b0);
		wr(`FACD_OFF_IRQ_MASK, 8'h02);
		chk(irq_o, 1'b1);
		pop({`FACD_ST0_INVALID});
		wr(`FACD_OFF_IRQ_STAT, 8'h0F);
		chk(irq_o, 1'b0);
		// read-only place: write must not land
		wr(`FACD_OFF_STATE, 8'h7F);
		rd(`FACD_OFF_STATE, 8'h80);
		send({`FACD_OP_SPECIFY, 8'hAF, 8'h1E});
		send({`FACD_OP_CONFIGURE, 8'h00, 8'h40, 8'h00});
		rd(`FACD_OFF_CONFIG, 8'h40);
		send({`FACD_OP_PERP, 8'h87});
		chk(drive_busy_o, 4'h0);
		send({8'h4D, 8'h01, 8'h02, 8'h12, 8'h1B, 8'hE5});
		pop(r7(24'h01_0000, XC));
		send({`FACD_OP_DUMP});
		pop({8'h00, 8'h00, 8'h00, 8'h00, 8'hAF, 8'h1E, 8'h12, 8'h07, 8'h40, 8'h00});
		fail <= 1'b1;
		foreach (ops[i])
		begin
			send({8'(ops[i]), 8'h01, 8'h05, 8'h00, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF});
			pop(r7(24'h51_0000, 32'h0300_0302));
		end
		rd(`FACD_OFF_IRQ_STAT, 8'h05);
		fail <= 1'b0;
		dly <= 8'h28;
		send({8'h46, 8'h01, 8'h05, 8'h00, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF});
		chk({seek_req_o, seek_drive_o, seek_cyl_o, drive_busy_o}, 15'h5052);
		pop(r7(24'h01_0000, XC));
		// overwrite bit clear: drive bits kept, gap and write gate replaced
		send({`FACD_OP_PERP, 8'h02});
		send({`FACD_OP_DUMP});
		pop({8'h00, 8'h05, 8'h00, 8'h00, 8'hAF, 8'h1E, 8'h09, 8'h06, 8'h40, 8'h00});
		bad <= 1'b1;
		send({8'h4A, 8'h05});
		pop(r7(24'h05_0000, IC));
		miss <= 1'b1;
		send({8'h4A, 8'h05});
		pop(r7(24'h45_0400, 32'h0000_0000));
		conclude();
	end
endmodule : facd_decoder_tb
